// [rtl/cantx_pkg.sv]
package cantx_pkg;

    // Register addresses on the CPU special-function bus.
    localparam logic [15:0] TRANSMIT_CONTROL_ADDR  = 16'hFFB1;
    localparam logic [15:0] BIT_TIMING_REG_LO_ADDR = 16'hFFB9;
    localparam logic [15:0] BIT_TIMING_REG_HI_ADDR = 16'hFFBA;

    // Reset values.
    localparam logic [7:0] TRANSMIT_CONTROL_RST  = 8'h00;
    localparam logic [7:0] BIT_TIMING_REG_LO_RST = 8'h18;
    localparam logic [7:0] BIT_TIMING_REG_HI_RST = 8'h0E;

    // Transmit control field positions.
    localparam int TCR_REQ_LSB   = 0;
    localparam int TCR_ABORT_LSB = 2;
    localparam int TCR_DONE_LSB  = 4;
    localparam int TCR_PRIO_BIT  = 7;

    // High bit-timing register option bits.
    localparam int LISTEN_ONLY_BIT   = 4;
    localparam int TRIPLE_SAMPLE_BIT = 5;
    localparam int FRAME_CLR_BIT     = 6;
    localparam int QUANTUM_RES_BIT   = 7;

    // Controller clocks per prescaler unit.
    localparam int CLKS_PER_UNIT = 2;

    // Completion record queue.
    localparam int EVT_FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ARB  = 2'b01,
        PH_XMIT = 2'b10
    } cantx_phase_t;

    // One record per finished request: which buffer and how it ended.
    typedef struct packed {
        logic buf_idx;
        logic complete;
    } cantx_evt_t;

    localparam int EVT_W = $bits(cantx_evt_t);

    // CPU register access, one byte.
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } cantx_cpu_t;

endpackage

// [rtl/cantx_ctrl.sv]
`timescale 1ns/1ps

module cantx_evt_fifo
#(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
)
(
    // Clock and reset.
    input  wire logic             i_ref_clk,
    input  wire logic             i_rstn,
    // Fill side.
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side.
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_r != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_r[rptr_r];

    always_ff @(posedge i_ref_clk)
    begin
        if (push)
        begin
            mem_r[wptr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
            end
            if (pop)
            begin
                rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module cantx_ctrl
    import cantx_pkg::*;
#(
    parameter int FIFO_DEPTH = EVT_FIFO_DEPTH
)
(
    // Clock and reset.
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    // CPU register access.
    input  wire cantx_cpu_t i_cpu,
    output logic [7:0]      o_cpu_rdata,
    // Controller control and status links.
    input  wire logic       i_init_req,
    input  wire logic       i_init_confirmed,
    input  wire logic       i_frame_start_source_sel,
    input  wire logic [7:0] i_bit_rate_divider,
    output logic            o_frame_start_clear,
    output logic            o_valid_msg_seen,
    output logic            o_err_count_en,
    // Protocol engine.
    input  wire logic       i_frame_slot,
    input  wire logic       i_arb_won,
    input  wire logic       i_arb_lost,
    input  wire logic       i_tx_ok,
    input  wire logic       i_tx_err,
    input  wire logic       i_engine_tx_bit,
    input  wire logic       i_rx_msg_valid,
    input  wire logic       i_rx_msg4_stored,
    input  wire logic       i_sample_pt,
    output logic            o_tx_start,
    output logic            o_tx_buf,
    output logic            o_tq_tick,
    output logic            o_rx_bit,
    // Bus pins.
    input  wire logic       i_can_rx,
    output logic            o_can_tx,
    // Completion records.
    output logic            o_evt_valid,
    input  wire logic       i_evt_ready,
    output cantx_evt_t      o_evt_data
);
    logic [1:0]   tx_req_r;
    logic [1:0]   tx_abort_r;
    logic [1:0]   tx_done_r;
    logic         tx_prio_r;
    logic [7:0]   timing_lo_r;
    logic [7:0]   timing_hi_r;
    cantx_phase_t phase_r;
    logic         cur_buf_r;
    logic [8:0]   tq_cnt_r;
    logic [2:0]   rx_hist_r;
    logic         listen_only;
    logic         wr_tcr;
    logic         frame_end;
    logic         end_clear;
    logic         end_done;
    logic         idle_abort;
    logic         idle_buf;
    logic         start_ok;
    logic         start_buf;
    logic [1:0]   clr_mask;
    logic [7:0]   div_eff;
    logic         fifo_ready;
    cantx_evt_t   evt_in;
    logic         evt_push;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    function automatic logic pick_buf(input logic [1:0] req,
                                      input logic       prio);
        pick_buf = (req == 2'b11) ? prio : req[1];
    endfunction

    assign listen_only = timing_hi_r[LISTEN_ONLY_BIT];
    assign wr_tcr      = i_cpu.wr && (i_cpu.addr == TRANSMIT_CONTROL_ADDR);

    // In listen-only mode recessive is forced on the line, which also silences acknowledge
    // and error flags that the engine might still generate.
    assign o_can_tx = listen_only ? 1'b1 : i_engine_tx_bit;
    assign o_err_count_en = !listen_only;

    // Frame completion from the engine and how it ends each buffer.
    assign frame_end = (phase_r == PH_ARB && i_arb_lost)
                    || (phase_r != PH_IDLE && (i_tx_ok || i_tx_err));
    always_comb
    begin
        end_clear = 1'b0;
        end_done  = 1'b0;
        if (phase_r == PH_ARB && i_arb_lost)
        begin
            end_clear = tx_abort_r[cur_buf_r];
        end
        else if (i_tx_ok)
        begin
            end_clear = 1'b1;
            end_done  = 1'b1;
        end
        else
        begin
            end_clear = tx_abort_r[cur_buf_r];
        end
    end

    // Aborts of queued buffers finish at once, but only while no frame
    // is in flight, so a queue slot is always left for the frame's end.
    assign idle_abort = (phase_r == PH_IDLE) && fifo_ready
                     && |(tx_abort_r & tx_req_r);
    assign idle_buf   = !(tx_abort_r[0] && tx_req_r[0]);

    // A frame starts only with room in the queue for its record.
    assign start_ok  = (phase_r == PH_IDLE) && i_frame_slot && fifo_ready
                    && !listen_only && !idle_abort
                    && |tx_req_r;
    assign start_buf = pick_buf(tx_req_r, tx_prio_r);

    always_comb
    begin
        clr_mask = 2'b00;
        if (frame_end && end_clear)
        begin
            clr_mask[cur_buf_r] = 1'b1;
        end
        else if (idle_abort)
        begin
            clr_mask[idle_buf] = 1'b1;
        end
    end

    // Request and abort: hardware clear first, then a CPU set, then init,
    // so a set landing in the clearing cycle is kept.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_req_r   <= TRANSMIT_CONTROL_RST[TCR_REQ_LSB +: 2];
            tx_abort_r <= TRANSMIT_CONTROL_RST[TCR_ABORT_LSB +: 2];
        end
        else
        begin
            logic [1:0] req_v;
            logic [1:0] abt_v;
            req_v = tx_req_r & ~clr_mask;
            abt_v = tx_abort_r & ~clr_mask;
            if (i_init_req)
            begin
                req_v = 2'b00;
                abt_v = 2'b00;
            end
            else if (wr_tcr)
            begin
                req_v = req_v | i_cpu.wdata[TCR_REQ_LSB +: 2];
                abt_v = abt_v | (i_cpu.wdata[TCR_ABORT_LSB +: 2]
                                 & req_v);
            end
            tx_req_r   <= req_v;
            tx_abort_r <= abt_v;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_done_r <= TRANSMIT_CONTROL_RST[TCR_DONE_LSB +: 2];
        end
        else if (frame_end && end_clear)
        begin
            tx_done_r[cur_buf_r] <= end_done;
        end
        else if (idle_abort)
        begin
            tx_done_r[idle_buf] <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_prio_r <= TRANSMIT_CONTROL_RST[TCR_PRIO_BIT];
        end
        else if (wr_tcr)
        begin
            tx_prio_r <= i_cpu.wdata[TCR_PRIO_BIT];
        end
    end

    // The frame runs to its own end; an abort only decides the outcome.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            phase_r   <= PH_IDLE;
            cur_buf_r <= 1'b0;
        end
        else
        begin
            case (phase_r)
                PH_IDLE:
                begin
                    if (start_ok)
                    begin
                        phase_r   <= PH_ARB;
                        cur_buf_r <= start_buf;
                    end
                end
                PH_ARB:
                begin
                    if (frame_end)
                    begin
                        phase_r <= PH_IDLE;
                    end
                    else if (i_arb_won)
                    begin
                        phase_r <= PH_XMIT;
                    end
                end
                PH_XMIT:
                begin
                    if (frame_end)
                    begin
                        phase_r <= PH_IDLE;
                    end
                end
                default:
                begin
                    phase_r <= PH_IDLE;
                end
            endcase
        end
    end

    assign o_tx_start = start_ok;
    assign o_tx_buf   = start_buf;

    // Completion records.
    assign evt_push         = |clr_mask;
    assign evt_in.buf_idx   = clr_mask[1];
    assign evt_in.complete  = frame_end && end_done;

    cantx_evt_fifo #(
        .WIDTH (EVT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_evt_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rstn      (i_rstn),
        .i_in_valid  (evt_push),
        .o_in_ready  (fifo_ready),
        .i_in_data   (evt_in),
        .o_out_valid (o_evt_valid),
        .i_out_ready (i_evt_ready),
        .o_out_data  (o_evt_data)
    );

    // Bit-timing registers are only taken in confirmed initialization,
    // since a change mid-traffic would corrupt the bus timing.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            timing_lo_r <= BIT_TIMING_REG_LO_RST;
            timing_hi_r <= BIT_TIMING_REG_HI_RST;
        end
        else if (i_cpu.wr && i_init_req && i_init_confirmed)
        begin
            if (i_cpu.addr == BIT_TIMING_REG_LO_ADDR)
            begin
                timing_lo_r <= i_cpu.wdata;
            end
            if (i_cpu.addr == BIT_TIMING_REG_HI_ADDR)
            begin
                timing_hi_r <= i_cpu.wdata;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_cpu_rdata <= 8'h00;
        end
        else if (i_cpu.rd)
        begin
            case (i_cpu.addr)
                TRANSMIT_CONTROL_ADDR:
                    o_cpu_rdata <= {tx_prio_r, 1'b0, tx_done_r,
                                    tx_abort_r, tx_req_r};
                BIT_TIMING_REG_LO_ADDR:
                    o_cpu_rdata <= timing_lo_r;
                BIT_TIMING_REG_HI_ADDR:
                    o_cpu_rdata <= timing_hi_r;
                default:
                    o_cpu_rdata <= 8'h00;
            endcase
        end
    end

    // Time quantum: each prescaler unit is two clocks. The counter has
    // nine bits, since a full divider needs 512 clocks per quantum.
    assign div_eff = timing_hi_r[QUANTUM_RES_BIT] ? i_bit_rate_divider
                   : {2'b00, i_bit_rate_divider[5:0]};
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tq_cnt_r  <= 9'h000;
            o_tq_tick <= 1'b0;
        end
        else
        begin
            o_tq_tick <= (tq_cnt_r == 9'h000);
            if (tq_cnt_r == 9'h000)
            begin
                tq_cnt_r <= 9'(CLKS_PER_UNIT * (int'(div_eff) + 1) - 1);
            end
            else
            begin
                tq_cnt_r <= tq_cnt_r - 9'h001;
            end
        end
    end

    // Three samples one quantum apart feed the majority vote.
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rx_hist_r <= 3'h7;
            o_rx_bit  <= 1'b1;
        end
        else
        begin
            if (o_tq_tick)
            begin
                rx_hist_r <= {rx_hist_r[1:0], i_can_rx};
            end
            if (i_sample_pt)
            begin
                o_rx_bit <= timing_hi_r[TRIPLE_SAMPLE_BIT]
                    ? ((rx_hist_r[0] & rx_hist_r[1])
                       | (rx_hist_r[0] & i_can_rx)
                       | (rx_hist_r[1] & i_can_rx))
                    : i_can_rx;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_valid_msg_seen    <= 1'b0;
            o_frame_start_clear <= 1'b0;
        end
        else
        begin
            if (i_rx_msg_valid)
            begin
                o_valid_msg_seen <= 1'b1;
            end
            else if (i_init_req)
            begin
                o_valid_msg_seen <= 1'b0;
            end
            o_frame_start_clear <= timing_hi_r[FRAME_CLR_BIT]
                && i_frame_start_source_sel && i_rx_msg4_stored;
        end
    end

    sequence s_abort_idle;
        phase_r == PH_IDLE && tx_abort_r[0] && tx_req_r[0] && fifo_ready
        && !wr_tcr;
    endsequence

    AST_LISTEN_TX: assert property (listen_only |-> o_can_tx)
        else $error("Transmit line driven in listen-only mode.");
    AST_LISTEN_START: assert property (listen_only |-> !o_tx_start)
        else $error("Frame started in listen-only mode.");
    AST_PRIO: assert property (o_tx_start && tx_req_r == 2'b11
        |-> o_tx_buf == tx_prio_r)
        else $error("Wrong buffer chosen on double request.");
    AST_ABORT_IDLE: assert property (s_abort_idle
        |=> !tx_req_r[0] && !tx_abort_r[0] && !tx_done_r[0])
        else $error("Idle abort did not finish cleanly.");
    AST_OK_DONE: assert property (phase_r == PH_XMIT && i_tx_ok
        && !i_init_req && !wr_tcr |=> !tx_req_r[$past(cur_buf_r)]
        && tx_done_r[$past(cur_buf_r)])
        else $error("Successful frame not completed.");
    AST_RETRY: assert property (phase_r == PH_XMIT && i_tx_err
        && !tx_abort_r[cur_buf_r] && !i_init_req
        |=> tx_req_r[$past(cur_buf_r)])
        else $error("Failed frame dropped its request.");
    AST_PAIR_CLR: assert property ($fell(tx_req_r[1])
        |-> !tx_abort_r[1])
        else $error("Abort left pending after request cleared.");
    AST_INIT_CLR: assert property (i_init_req
        |=> tx_req_r == 2'b00 && tx_abort_r == 2'b00)
        else $error("Init did not clear requests.");
    AST_NO_TRUNC: assert property (phase_r == PH_XMIT
        && !(i_tx_ok || i_tx_err) |=> phase_r == PH_XMIT)
        else $error("Frame left transmit phase early.");
endmodule

// [testbench/cantx_engine_model.sv]
`timescale 1ns/1ps

module cantx_engine_model
#(
    parameter int ARB_CYC  = 3,
    parameter int XMIT_CYC = 16
)
(
    // Clock and reset.
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    // Frame start and the outcome to play back.
    input  wire logic       i_tx_start,
    input  wire logic [1:0] i_mode,
    // Frame events.
    output logic            o_arb_won,
    output logic            o_arb_lost,
    output logic            o_tx_ok,
    output logic            o_tx_err,
    output logic            o_engine_tx_bit
);
    // Mode 0 clean frame, 1 error, 2 lost arbitration, 3 dominant request.
    logic [1:0] phase_r;
    logic [7:0] cnt_r;
    logic       bit_r;

    // The bit toggles in the transmit phase so a stale level never looks valid.
    assign o_engine_tx_bit = (phase_r == 2'd2) ? bit_r : (i_mode != 2'd3);

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            phase_r    <= 2'd0;
            cnt_r      <= 8'h00;
            bit_r      <= 1'b1;
            o_arb_won  <= 1'b0;
            o_arb_lost <= 1'b0;
            o_tx_ok    <= 1'b0;
            o_tx_err   <= 1'b0;
        end
        else
        begin
            o_arb_won  <= 1'b0;
            o_arb_lost <= 1'b0;
            o_tx_ok    <= 1'b0;
            o_tx_err   <= 1'b0;
            cnt_r      <= cnt_r + 8'h01;
            bit_r      <= ~bit_r;
            if (phase_r == 2'd0)
            begin
                cnt_r   <= 8'h00;
                phase_r <= i_tx_start ? 2'd1 : 2'd0;
            end
            else if (phase_r == 2'd1 && cnt_r == 8'(ARB_CYC - 1))
            begin
                cnt_r      <= 8'h00;
                o_arb_lost <= (i_mode == 2'd2);
                o_arb_won  <= (i_mode != 2'd2);
                phase_r    <= (i_mode == 2'd2) ? 2'd0 : 2'd2;
            end
            else if (phase_r == 2'd2 && cnt_r == 8'(XMIT_CYC - 1))
            begin
                o_tx_ok  <= (i_mode != 2'd1);
                o_tx_err <= (i_mode == 2'd1);
                phase_r  <= 2'd0;
            end
        end
    end
endmodule

// [testbench/cantx_ctrl_bench.sv]
`timescale 1ns/1ps

module cantx_ctrl_bench
    import cantx_pkg::*;
;
    localparam logic [15:0] A_TC = TRANSMIT_CONTROL_ADDR;
    localparam logic [15:0] A_LO = BIT_TIMING_REG_LO_ADDR;
    localparam logic [15:0] A_HI = BIT_TIMING_REG_HI_ADDR;

    logic       clk = 1'b0, rstn = 1'b0;
    cantx_cpu_t cpu = '0;
    logic [7:0] rdata, div = 8'h03;
    logic [1:0] mode = 2'd0;
    logic       init_req = 1'b0, init_conf = 1'b0, fs_sel = 1'b0;
    logic       slot = 1'b0, rx_valid = 1'b0, msg4 = 1'b0, sample_point_pos = 1'b0;
    logic       can_rx = 1'b1, evt_ready = 1'b0;
    logic       fs_clr, vms, ecnt_en, tx_start, tx_buf, tq_tick, rx_bit;
    logic       can_tx, evt_valid, arb_won, arb_lost, tx_ok, tx_err, eng_bit;
    cantx_evt_t evt_data;
    int         n_mismatch = 0, checks_done = 0;

    always #12.5 clk = ~clk;

    // A small record queue keeps the full-queue case short.
    cantx_ctrl #(.FIFO_DEPTH(4)) dut (
        .i_ref_clk(clk), .i_rstn(rstn), .i_cpu(cpu), .o_cpu_rdata(rdata),
        .i_init_req(init_req), .i_init_confirmed(init_conf),
        .i_frame_start_source_sel(fs_sel), .i_bit_rate_divider(div),
        .o_frame_start_clear(fs_clr), .o_valid_msg_seen(vms),
        .o_err_count_en(ecnt_en), .i_frame_slot(slot), .i_arb_won(arb_won),
        .i_arb_lost(arb_lost), .i_tx_ok(tx_ok), .i_tx_err(tx_err),
        .i_engine_tx_bit(eng_bit), .i_rx_msg_valid(rx_valid),
        .i_rx_msg4_stored(msg4), .i_sample_pt(sample_point_pos), .o_tx_start(tx_start),
        .o_tx_buf(tx_buf), .o_tq_tick(tq_tick), .o_rx_bit(rx_bit),
        .i_can_rx(can_rx), .o_can_tx(can_tx), .o_evt_valid(evt_valid),
        .i_evt_ready(evt_ready), .o_evt_data(evt_data));

    cantx_engine_model eng (
        .i_ref_clk(clk), .i_rstn(rstn), .i_tx_start(tx_start),
        .i_mode(mode), .o_arb_won(arb_won), .o_arb_lost(arb_lost),
        .o_tx_ok(tx_ok), .o_tx_err(tx_err), .o_engine_tx_bit(eng_bit));

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic stuck();
        n_mismatch++;
        test_done();
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        cpu.addr = a;
        cpu.wdata = d;
        cpu.wr = 1'b1;
        @(negedge clk);
        cpu.wr = 1'b0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        cpu.addr = a;
        cpu.rd = 1'b1;
        @(negedge clk);
        cpu.rd = 1'b0;
        chk8("read data", e, rdata);
    endtask

    task automatic frame(input logic [1:0] m, input logic s, b);
        @(negedge clk);
        mode = m;
        slot = 1'b1;
        #1;
        chk1("frame start", s, tx_start);
        if (s)
            chk1("frame buffer", b, tx_buf);
        @(negedge clk);
        slot = 1'b0;
    endtask

    task automatic frame_end();
        int i;
        for (i = 0; i < 200 && !(tx_ok || tx_err || arb_lost); i++)
            @(negedge clk);
        if (i == 200)
            stuck();
        tick(1);
    endtask

    task automatic evt(input logic b, c);
        int i;
        for (i = 0; i < 200 && evt_valid !== 1'b1; i++)
            @(negedge clk);
        if (i == 200)
            stuck();
        chk1("record buffer", b, evt_data.buf_idx);
        chk1("record outcome", c, evt_data.complete);
        evt_ready = 1'b1;
        @(negedge clk);
        evt_ready = 1'b0;
        tick(1);
    endtask

    task automatic t_reset();
        rdc(A_TC, 8'h00);
        rdc(A_LO, BIT_TIMING_REG_LO_RST);
        rdc(A_HI, BIT_TIMING_REG_HI_RST);
        rdc(16'hFFB0, 8'h00);
        chk1("record valid", 1'b0, evt_valid);
        $display("test reset done");
    endtask

    task automatic t_bits();
        wr(A_TC, 8'hF0);
        rdc(A_TC, 8'h80);
        wr(A_TC, 8'h04);
        rdc(A_TC, 8'h00);
        wr(A_TC, 8'h01);
        wr(A_TC, 8'h02);
        rdc(A_TC, 8'h03);
        init_req = 1'b1;
        tick(1);
        init_req = 1'b0;
        rdc(A_TC, 8'h00);
        $display("test bits done");
    endtask

    task automatic t_prio();
        for (int p = 0; p < 2; p++)
        begin
            wr(A_TC, {p[0], 7'h03});
            frame(2'd0, 1'b1, p[0]);
            evt(p[0], 1'b1);
            frame(2'd0, 1'b1, !p[0]);
            evt(!p[0], 1'b1);
            rdc(A_TC, p[0] ? 8'hB0 : 8'h30);
        end
        $display("test priority done");
    endtask

    task automatic t_retry();
        wr(A_TC, 8'h01);
        frame(2'd1, 1'b1, 1'b0);
        frame_end();
        rdc(A_TC, 8'h31);
        frame(2'd0, 1'b1, 1'b0);
        evt(1'b0, 1'b1);
        rdc(A_TC, 8'h30);
        $display("test retry done");
    endtask

    task automatic t_abort();
        wr(A_TC, 8'h01);
        wr(A_TC, 8'h04);
        evt(1'b0, 1'b0);
        rdc(A_TC, 8'h20);
        wr(A_TC, 8'h01);
        frame(2'd2, 1'b1, 1'b0);
        wr(A_TC, 8'h04);
        evt(1'b0, 1'b0);
        rdc(A_TC, 8'h20);
        for (int m = 0; m < 2; m++)
        begin
            wr(A_TC, 8'h01);
            frame(2'(m), 1'b1, 1'b0);
            tick(6);
            wr(A_TC, 8'h04);
            rdc(A_TC, m ? 8'h35 : 8'h25);
            evt(1'b0, m == 0);
            rdc(A_TC, m ? 8'h20 : 8'h30);
        end
        $display("test abort done");
    endtask

    task automatic t_fifo();
        for (int k = 0; k < 4; k++)
        begin
            wr(A_TC, 8'h01);
            wr(A_TC, 8'h04);
        end
        wr(A_TC, 8'h01);
        frame(2'd0, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++)
            evt(1'b0, 1'b0);
        tick(1);
        chk1("record valid", 1'b0, evt_valid);
        frame(2'd0, 1'b1, 1'b0);
        evt(1'b0, 1'b1);
        $display("test queue done");
    endtask

    task automatic t_listen();
        init_req = 1'b1;
        wr(A_LO, 8'h55);
        rdc(A_LO, BIT_TIMING_REG_LO_RST);
        init_conf = 1'b1;
        wr(A_HI, 8'h1E);
        rdc(A_HI, 8'h1E);
        init_req = 1'b0;
        init_conf = 1'b0;
        mode = 2'd3;
        tick(1);
        chk1("tx line", 1'b1, can_tx);
        chk1("error count enable", 1'b0, ecnt_en);
        wr(A_TC, 8'h01);
        frame(2'd3, 1'b0, 1'b0);
        init_req = 1'b1;
        init_conf = 1'b1;
        wr(A_HI, 8'h0E);
        init_req = 1'b0;
        init_conf = 1'b0;
        tick(1);
        chk1("tx line", 1'b0, can_tx);
        chk1("error count enable", 1'b1, ecnt_en);
        mode = 2'd0;
        $display("test listen done");
    endtask

    task automatic t_misc();
        int i;
        int n;
        int q;
        fs_sel = 1'b1;
        msg4 = 1'b1;
        tick(1);
        msg4 = 1'b0;
        chk1("frame start clear", 1'b0, fs_clr);
        init_req = 1'b1;
        init_conf = 1'b1;
        wr(A_HI, 8'h4E);
        init_req = 1'b0;
        init_conf = 1'b0;
        msg4 = 1'b1;
        tick(1);
        msg4 = 1'b0;
        chk1("frame start clear", 1'b1, fs_clr);
        tick(1);
        chk1("frame start clear", 1'b0, fs_clr);
        can_rx = 1'b0;
        sample_point_pos = 1'b1;
        tick(1);
        sample_point_pos = 1'b0;
        can_rx = 1'b1;
        chk1("sampled bit", 1'b0, rx_bit);
        div = 8'hC3;
        for (i = 0; i < 100 && tq_tick !== 1'b1; i++)
            @(negedge clk);
        @(negedge clk);
        for (n = 1; n < 100 && tq_tick !== 1'b1; n++)
            @(negedge clk);
        if (i == 100 || n == 100)
            stuck();
        q = CLKS_PER_UNIT * ((div & 8'h3F) + 1);
        chk8("quantum period", 8'(q), 8'(n));
        chk1("valid message seen", 1'b0, vms);
        rx_valid = 1'b1;
        tick(1);
        rx_valid = 1'b0;
        tick(1);
        chk1("valid message seen", 1'b1, vms);
        init_req = 1'b1;
        init_conf = 1'b1;
        wr(A_HI, 8'h2E);
        init_req = 1'b0;
        init_conf = 1'b0;
        can_rx = 1'b0;
        sample_point_pos = 1'b1;
        tick(1);
        sample_point_pos = 1'b0;
        can_rx = 1'b1;
        chk1("voted bit", 1'b1, rx_bit);
        $display("test options done");
    endtask

    initial
    begin
        tick(8);
        rstn = 1'b1;
        t_reset();
        t_bits();
        t_prio();
        t_retry();
        t_abort();
        t_fifo();
        t_listen();
        t_misc();
        test_done();
    end
endmodule
